/* core/frequency_protection_element.sv */
// Frequency protection element with Avalon-MM register access and interrupt.
// Assumes per-phase frequency, gradient and voltage values synchronous to clk.
`timescale 1ns/1ps
module frequency_protection_element #(
  parameter int TICK_CYCLES = freq_prot_pkg::TICK_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Avalon-MM slave.
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Measurement front end.
  input wire logic [15:0] voltagePhaseAb,
  input wire logic [15:0] voltagePhaseBc,
  input wire logic [15:0] voltagePhaseCa,
  input wire logic [15:0] freqAb,
  input wire logic [15:0] freqBc,
  input wire logic [15:0] freqCa,
  input wire logic signed [15:0] freqGradientAb,
  input wire logic signed [15:0] freqGradientBc,
  input wire logic signed [15:0] freqGradientCa,
  input wire logic surgeDetect,
  input wire logic phaseLoss,
  // Protection commands.
  input wire logic extBlock,
  output logic alarm,
  output logic trip,
  output logic mainsFailTrip,
  output logic irq
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Merges write data into a register under the byte enables.
  function automatic logic [31:0] mergeBe(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Frequency comparison, over or under the pickup threshold.
  function automatic logic freqPass(input logic [15:0] f, input logic [15:0] thr,
                                    input logic over);
    return over ? (f > thr) : (f < thr);
  endfunction

  // Gradient comparison in the selected direction.
  function automatic logic gradPass(input logic signed [15:0] g, input logic [15:0] thr,
                                    input logic [1:0] dir);
    logic signed [16:0] gs;
    logic signed [16:0] ts;
    gs = {g[15], g};
    ts = {1'b0, thr};
    unique case (dir)
      freq_prot_pkg::DIR_POS: return gs >= ts;
      freq_prot_pkg::DIR_NEG: return -gs >= ts;
      freq_prot_pkg::DIR_ABS: return (gs >= ts) || (-gs >= ts);
      default: return 1'b0;
    endcase
  endfunction

  // Change since the reference in the pickup direction reaches the threshold.
  function automatic logic changePass(input logic [15:0] f, input logic [15:0] base,
                                      input logic [15:0] thr, input logic over);
    logic signed [16:0] d;
    d = over ? ($signed({1'b0, f}) - $signed({1'b0, base}))
             : ($signed({1'b0, base}) - $signed({1'b0, f}));
    return d >= $signed({1'b0, thr});
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------

  logic [5:0] ctrl;
  logic [15:0] freqThr;
  logic [15:0] gradThr;
  logic [15:0] changeThr;
  logic [15:0] tripDelay;
  logic [15:0] supervisionInterval;
  logic [15:0] uvThr;
  logic [3:0] status;
  logic [3:0] mask;
  freq_prot_pkg::state_e state;
  freq_prot_pkg::state_e next_state;
  logic [15:0] timer;
  logic [15:0] ref0;
  logic [15:0] ref1;
  logic [15:0] ref2;
  logic [31:0] tickCnt;
  logic tick;
  logic [10:0] uvHoldCnt;
  logic [10:0] gradZeroCnt;
  logic alarmPrev;
  logic tripPrev;
  logic surgePrev;
  logic uvPrev;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------

  wire busReq = read || write;
  wire busDone = busReq && !waitrequest;
  wire wrEn = write && busDone;
  wire [31:0] wrCtrl = mergeBe({26'h000_0000, ctrl}, writedata, byteenable);
  wire [31:0] wrFreq = mergeBe({16'h0000, freqThr}, writedata, byteenable);
  wire [31:0] wrGrad = mergeBe({16'h0000, gradThr}, writedata, byteenable);
  wire [31:0] wrChg = mergeBe({16'h0000, changeThr}, writedata, byteenable);
  wire [31:0] wrDelay = mergeBe({16'h0000, tripDelay}, writedata, byteenable);
  wire [31:0] wrIntv = mergeBe({16'h0000, supervisionInterval}, writedata, byteenable);
  wire [31:0] wrUv = mergeBe({16'h0000, uvThr}, writedata, byteenable);
  wire [31:0] wrMask = mergeBe({28'h000_0000, mask}, writedata, byteenable);
  wire [3:0] clrStatus = (wrEn && address == freq_prot_pkg::OFS_STATUS && byteenable[0])
                         ? writedata[3:0] : 4'h0;
  wire [3:0] stateBits = {uvPrev, surgePrev, tripPrev, alarmPrev};
  wire [31:0] rdMux =
    (address == freq_prot_pkg::OFS_CTRL) ? {26'h000_0000, ctrl} :
    (address == freq_prot_pkg::OFS_FREQ_THR) ? {16'h0000, freqThr} :
    (address == freq_prot_pkg::OFS_GRAD_THR) ? {16'h0000, gradThr} :
    (address == freq_prot_pkg::OFS_CHANGE_THR) ? {16'h0000, changeThr} :
    (address == freq_prot_pkg::OFS_TRIP_DELAY) ? {16'h0000, tripDelay} :
    (address == freq_prot_pkg::OFS_INTERVAL) ? {16'h0000, supervisionInterval} :
    (address == freq_prot_pkg::OFS_UV_THR) ? {16'h0000, uvThr} :
    (address == freq_prot_pkg::OFS_STATUS) ? {28'h000_0000, status} :
    (address == freq_prot_pkg::OFS_MASK) ? {28'h000_0000, mask} :
    (address == freq_prot_pkg::OFS_STATE) ? {26'h000_0000, state, stateBits} :
    32'h0000_0000;

  // ----------------------------------------------------------------
  // Configuration fields
  // ----------------------------------------------------------------

  wire enable = ctrl[freq_prot_pkg::CTRL_EN_BIT];
  wire [2:0] mode = ctrl[freq_prot_pkg::CTRL_MODE_LSB +: 3];
  wire [1:0] dir = ctrl[freq_prot_pkg::CTRL_DIR_LSB +: 2];
  wire isOver = (mode == freq_prot_pkg::MODE_OVER_GRAD) ||
                (mode == freq_prot_pkg::MODE_OVER_CHG);
  wire isComb = (mode == freq_prot_pkg::MODE_UNDER_GRAD) ||
                (mode == freq_prot_pkg::MODE_OVER_GRAD);
  wire isChg = (mode == freq_prot_pkg::MODE_UNDER_CHG) ||
               (mode == freq_prot_pkg::MODE_OVER_CHG);
  wire isGrad = (mode == freq_prot_pkg::MODE_GRAD);

  // ----------------------------------------------------------------
  // Undervoltage lockout
  // ----------------------------------------------------------------

  wire allLow = (voltagePhaseAb < uvThr) && (voltagePhaseBc < uvThr) &&
                (voltagePhaseCa < uvThr);
  wire uvBlock = allLow || (uvHoldCnt != 11'h000);
  wire gradZero = allLow || (gradZeroCnt != 11'h000);
  wire blocked = extBlock || uvBlock || !enable;

  // ----------------------------------------------------------------
  // Per-phase comparisons
  // ----------------------------------------------------------------

  wire signed [15:0] gAb = gradZero ? 16'sh0000 : freqGradientAb;
  wire signed [15:0] gBc = gradZero ? 16'sh0000 : freqGradientBc;
  wire signed [15:0] gCa = gradZero ? 16'sh0000 : freqGradientCa;
  wire [2:0] fOk = {freqPass(freqCa, freqThr, isOver), freqPass(freqBc, freqThr, isOver),
                    freqPass(freqAb, freqThr, isOver)};
  wire [2:0] gOk = {gradPass(gCa, gradThr, dir), gradPass(gBc, gradThr, dir),
                    gradPass(gAb, gradThr, dir)};
  wire [2:0] cOk = {changePass(freqCa, ref2, changeThr, isOver),
                    changePass(freqBc, ref1, changeThr, isOver),
                    changePass(freqAb, ref0, changeThr, isOver)};
  wire gradPick = |gOk;
  wire combPick = |(fOk & gOk);
  wire freqPick = |fOk;
  wire changeHit = |(fOk & cOk);
  wire pick = isGrad ? gradPick : isComb ? combPick : isChg ? freqPick : 1'b0;
  wire timerDone = (timer == 16'h0000);
  wire [15:0] timerLoad = isChg ? supervisionInterval : tripDelay;

  // ----------------------------------------------------------------
  // Element state machine
  // ----------------------------------------------------------------

  always_comb begin
    next_state = state;
    unique case (state)
      freq_prot_pkg::IDLE: begin
        if (!blocked && pick) begin
          next_state = freq_prot_pkg::TIMING;
        end
      end
      freq_prot_pkg::TIMING: begin
        if (blocked || !pick) begin
          next_state = freq_prot_pkg::IDLE;
        end else if (isChg && changeHit) begin
          next_state = freq_prot_pkg::TRIPPED;
        end else if (isChg && timerDone) begin
          next_state = freq_prot_pkg::EXPIRED;
        end else if (!isChg && timerDone) begin
          next_state = freq_prot_pkg::TRIPPED;
        end
      end
      freq_prot_pkg::TRIPPED: begin
        if (blocked || !pick) begin
          next_state = freq_prot_pkg::IDLE;
        end
      end
      freq_prot_pkg::EXPIRED: begin
        if (blocked || !freqPick || !isChg) begin
          next_state = freq_prot_pkg::IDLE;
        end
      end
    endcase
  end

  wire next_alarm = (next_state == freq_prot_pkg::TIMING) ||
                    (next_state == freq_prot_pkg::TRIPPED);
  wire next_trip = (next_state == freq_prot_pkg::TRIPPED);
  wire next_surge = (mode == freq_prot_pkg::MODE_SURGE) && enable && surgeDetect &&
                    !uvBlock && !phaseLoss && !extBlock;
  wire [3:0] events = {uvBlock && !uvPrev, next_surge && !surgePrev,
                       next_trip && !tripPrev, next_alarm && !alarmPrev};

  // ----------------------------------------------------------------
  // Sequential logic
  // ----------------------------------------------------------------

  always_ff @(posedge clk) begin
    if (!nrst) begin
      tickCnt <= 32'h0000_0000;
      tick <= 1'b0;
    end else begin
      tick <= (tickCnt == 32'(TICK_CYCLES - 1));
      tickCnt <= (tickCnt == 32'(TICK_CYCLES - 1)) ? 32'h0000_0000 : tickCnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      uvHoldCnt <= 11'h000;
      gradZeroCnt <= 11'h000;
    end else if (allLow) begin
      uvHoldCnt <= 11'(freq_prot_pkg::UV_HOLD_MS + 1);
      gradZeroCnt <= 11'(freq_prot_pkg::GRAD_ZERO_MS);
    end else if (tick) begin
      uvHoldCnt <= (uvHoldCnt != 11'h000) ? uvHoldCnt - 11'h001 : 11'h000;
      gradZeroCnt <= (gradZeroCnt != 11'h000) ? gradZeroCnt - 11'h001 : 11'h000;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= freq_prot_pkg::IDLE;
      timer <= 16'h0000;
    end else begin
      state <= next_state;
      if (state != freq_prot_pkg::TIMING) begin
        timer <= timerLoad;
      end else if (tick && !timerDone) begin
        timer <= timer - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ref0 <= 16'h0000;
      ref1 <= 16'h0000;
      ref2 <= 16'h0000;
    end else if (state == freq_prot_pkg::IDLE) begin
      ref0 <= freqAb;
      ref1 <= freqBc;
      ref2 <= freqCa;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      alarm <= 1'b0;
      trip <= 1'b0;
      mainsFailTrip <= 1'b0;
      alarmPrev <= 1'b0;
      tripPrev <= 1'b0;
      surgePrev <= 1'b0;
      uvPrev <= 1'b0;
    end else begin
      alarm <= next_alarm;
      trip <= next_trip;
      mainsFailTrip <= next_surge;
      alarmPrev <= next_alarm;
      tripPrev <= next_trip;
      surgePrev <= next_surge;
      uvPrev <= uvBlock;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      status <= 4'h0;
      irq <= 1'b0;
    end else begin
      status <= (status & ~clrStatus) | events;
      irq <= |(((status & ~clrStatus) | events) & mask);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      waitrequest <= 1'b1;
      readdata <= 32'h0000_0000;
    end else begin
      waitrequest <= !(busReq && waitrequest);
      if (busReq && waitrequest) begin
        readdata <= read ? rdMux : 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl <= freq_prot_pkg::CTRL_RESET;
      freqThr <= freq_prot_pkg::THR_RESET;
      gradThr <= freq_prot_pkg::THR_RESET;
      changeThr <= freq_prot_pkg::THR_RESET;
      tripDelay <= freq_prot_pkg::THR_RESET;
      supervisionInterval <= freq_prot_pkg::THR_RESET;
      uvThr <= freq_prot_pkg::THR_RESET;
      mask <= 4'h0;
    end else if (wrEn) begin
      unique case (address)
        freq_prot_pkg::OFS_CTRL: ctrl <= wrCtrl[5:0];
        freq_prot_pkg::OFS_FREQ_THR: freqThr <= wrFreq[15:0];
        freq_prot_pkg::OFS_GRAD_THR: gradThr <= wrGrad[15:0];
        freq_prot_pkg::OFS_CHANGE_THR: changeThr <= wrChg[15:0];
        freq_prot_pkg::OFS_TRIP_DELAY: tripDelay <= wrDelay[15:0];
        freq_prot_pkg::OFS_INTERVAL: supervisionInterval <= wrIntv[15:0];
        freq_prot_pkg::OFS_UV_THR: uvThr <= wrUv[15:0];
        freq_prot_pkg::OFS_MASK: mask <= wrMask[3:0];
        default: begin
        end
      endcase
    end
  end

endmodule

/* core/freq_prot_pkg.sv */
// Constants, register map and field layout of the frequency protection element.
// Assumes a 250 MHz clock and an Avalon-MM master that keeps its request standing.
// Notes on behaviour
// - All three line voltages below the undervoltage threshold inhibit every element mode.
// - The configured mode selects which comparisons form pickup and trip.
// - External blocking suppresses alarm and trip in every mode.
// - Gradient mode: gradient past threshold raises alarm and starts the trip delay.
// - Gradient mode: trip at delay expiry only if the gradient still passes.
// - Direction setting selects rising, falling or both gradient directions.
// - Combined modes hold frequency threshold, gradient threshold and trip delay.
// - Combined mode: frequency and gradient both passing raise alarm, start delay.
// - Combined mode: trip at expiry only if both conditions still hold.
// - Interval mode holds frequency threshold, change threshold and supervision interval.
// - Interval mode: frequency past threshold raises alarm and starts the interval.
// - Interval mode: trip when change reaches threshold inside the interval.
// - Interval expired without change: no trip, inhibited until a fresh crossing.
// - Vector surge is blocked at low voltage, faster than the surge path.
// - Loss of a measuring phase inhibits vector surge tripping.
// - Vector surge signals mains failure well within its detection time.
// - After voltage recovery, blocking holds 0.5 s and gradient reads zero 1 s.
package freq_prot_pkg;

  localparam int DATA_W = 16;
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int UV_HOLD_MS = 500;
  localparam int GRAD_ZERO_MS = 1000;
  localparam int VS_DETECT_MS = 60;

  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_FREQ_THR = 6'h04;
  localparam logic [5:0] OFS_GRAD_THR = 6'h08;
  localparam logic [5:0] OFS_CHANGE_THR = 6'h0C;
  localparam logic [5:0] OFS_TRIP_DELAY = 6'h10;
  localparam logic [5:0] OFS_INTERVAL = 6'h14;
  localparam logic [5:0] OFS_UV_THR = 6'h18;
  localparam logic [5:0] OFS_STATUS = 6'h1C;
  localparam logic [5:0] OFS_MASK = 6'h20;
  localparam logic [5:0] OFS_STATE = 6'h24;

  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_DIR_LSB = 4;
  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam logic [15:0] THR_RESET = 16'h0000;

  localparam logic [2:0] MODE_GRAD = 3'h0;
  localparam logic [2:0] MODE_UNDER_GRAD = 3'h1;
  localparam logic [2:0] MODE_OVER_GRAD = 3'h2;
  localparam logic [2:0] MODE_UNDER_CHG = 3'h3;
  localparam logic [2:0] MODE_OVER_CHG = 3'h4;
  localparam logic [2:0] MODE_SURGE = 3'h5;

  localparam logic [1:0] DIR_POS = 2'h0;
  localparam logic [1:0] DIR_NEG = 2'h1;
  localparam logic [1:0] DIR_ABS = 2'h2;

  localparam int ST_ALARM = 0;
  localparam int ST_TRIP = 1;
  localparam int ST_SURGE = 2;
  localparam int ST_UV = 3;
  localparam int ST_W = 4;

  typedef enum logic [1:0] {IDLE, TIMING, TRIPPED, EXPIRED} state_e;

endpackage

/* tb/freq_prot_asserts.sv */
// Concurrent checks on the ports of the frequency protection element.
// Assumes a bind to the design's top module with one clock and nrst.
`timescale 1ns/1ps
module freq_prot_asserts #(
  parameter int TICK_CYCLES = 10
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Register bus.
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // Element signals.
  input wire logic surgeDetect,
  input wire logic phaseLoss,
  input wire logic extBlock,
  input wire logic alarm,
  input wire logic trip,
  input wire logic mainsFailTrip,
  input wire logic irq
);
  // ------------------------------------------------------------
  // Properties.
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_block_clears:
    assert property (extBlock |=> !alarm && !trip) else $error("Output while blocked.");
  a_alarm_unblocked:
    assert property ($rose(alarm) |-> !$past(extBlock)) else $error("Alarm rose when blocked.");
  a_trip_with_alarm:
    assert property (trip |-> alarm) else $error("Trip without alarm.");
  a_trip_after_alarm:
    assert property ($rose(trip) |-> $past(alarm)) else $error("Trip before alarm.");
  a_surge_loss:
    assert property (phaseLoss |=> !mainsFailTrip) else $error("Surge trip on phase loss.");
  a_surge_cause:
    assert property (mainsFailTrip |-> $past(surgeDetect) && !$past(extBlock))
      else $error("Surge trip without cause.");
  a_wait_pulse:
    assert property (!waitrequest |=> waitrequest) else $error("Wait low too long.");
  a_bus_answer:
    assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("No bus answer.");
  a_unmapped_zero:
    assert property (read && !waitrequest && address > 6'h24 |-> readdata == 32'h0000_0000)
      else $error("Unmapped read not zero.");
  c_trip: cover property ($rose(trip));
  c_surge: cover property ($rose(mainsFailTrip));
  c_irq: cover property ($rose(irq));
endmodule

/* tb/freq_front_end_model.sv */
// Front end model: line voltages, frequencies and gradients.
// Assumes the bench picks one disturbed phase; the others stay nominal.
`timescale 1ns/1ps
module freq_front_end_model #(
  parameter logic [15:0] NOM_FREQ = 16'h1388
) (
  // Settings from the bench.
  input wire logic [15:0] setVolt,
  input wire logic [15:0] setFreq,
  input wire logic signed [15:0] setGrad,
  input wire logic [1:0] setPhase,
  input wire logic setSurge,
  input wire logic setLoss,
  // Measured values.
  output logic [15:0] voltagePhaseAb,
  output logic [15:0] voltagePhaseBc,
  output logic [15:0] voltagePhaseCa,
  output logic [15:0] freqAb,
  output logic [15:0] freqBc,
  output logic [15:0] freqCa,
  output logic signed [15:0] freqGradientAb,
  output logic signed [15:0] freqGradientBc,
  output logic signed [15:0] freqGradientCa,
  output logic surgeDetect,
  output logic phaseLoss
);
  assign voltagePhaseAb = setVolt;
  assign voltagePhaseBc = setVolt;
  assign voltagePhaseCa = setVolt;
  assign freqAb = (setPhase == 2'h0) ? setFreq : NOM_FREQ;
  assign freqBc = (setPhase == 2'h1) ? setFreq : NOM_FREQ;
  assign freqCa = (setPhase == 2'h2) ? setFreq : NOM_FREQ;
  assign freqGradientAb = (setPhase == 2'h0) ? setGrad : 16'sh0000;
  assign freqGradientBc = (setPhase == 2'h1) ? setGrad : 16'sh0000;
  assign freqGradientCa = (setPhase == 2'h2) ? setGrad : 16'sh0000;
  assign surgeDetect = setSurge;
  assign phaseLoss = setLoss;
endmodule

/* tb/frequency_protection_element_tb.sv */
// Self-checking bench for the frequency protection element.
// Assumes a 1 ms tick of 10 cycles and the front end model beside it.
`timescale 1ns/1ps
module frequency_protection_element_tb;
  typedef struct packed {
    logic [2:0] m;
    logic [1:0] d;
    logic [15:0] thr;
    logic [15:0] f;
    logic [15:0] g;
    logic e;
  } case_s;
  localparam int TICK = 10;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [5:0] address = 6'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [31:0] readdata, q;
  logic waitrequest, surgeDetect, phaseLoss, alarm, trip, mainsFailTrip, irq;
  logic [15:0] setVolt = 16'h1000;
  logic [15:0] setFreq = 16'h1388;
  logic signed [15:0] setGrad = 16'sh0000;
  logic [1:0] setPhase = 2'h0;
  logic setSurge = 1'b0;
  logic setLoss = 1'b0;
  logic extBlock = 1'b0;
  logic [15:0] vAb, vBc, vCa, fAb, fBc, fCa;
  logic signed [15:0] gAb, gBc, gCa;
  int n_mismatch = 0;
  int num_checks = 0;
  case_s cases [11] = '{
    '{3'h0, 2'h0, 16'h0000, 16'h1388, 16'h0020, 1'b1},
    '{3'h0, 2'h0, 16'h0000, 16'h1388, 16'hFFE0, 1'b0},
    '{3'h0, 2'h1, 16'h0000, 16'h1388, 16'hFFE0, 1'b1},
    '{3'h0, 2'h1, 16'h0000, 16'h1388, 16'h0020, 1'b0},
    '{3'h0, 2'h2, 16'h0000, 16'h1388, 16'hFFE0, 1'b1},
    '{3'h1, 2'h1, 16'h1300, 16'h1200, 16'hFFE0, 1'b1},
    '{3'h1, 2'h1, 16'h1300, 16'h1388, 16'hFFE0, 1'b0},
    '{3'h2, 2'h0, 16'h1400, 16'h1500, 16'h0020, 1'b1},
    '{3'h2, 2'h0, 16'h1400, 16'h1500, 16'h0000, 1'b0},
    '{3'h4, 2'h0, 16'h1400, 16'h1500, 16'h0000, 1'b1},
    '{3'h0, 2'h3, 16'h0000, 16'h1388, 16'h0020, 1'b0}};
  always #2 clk = ~clk;
  freq_front_end_model freq_front_end_model_inst (.setVolt(setVolt), .setFreq(setFreq),
    .setGrad(setGrad), .setPhase(setPhase), .setSurge(setSurge), .setLoss(setLoss),
    .voltagePhaseAb(vAb), .voltagePhaseBc(vBc), .voltagePhaseCa(vCa), .freqAb(fAb),
    .freqBc(fBc), .freqCa(fCa), .freqGradientAb(gAb), .freqGradientBc(gBc),
    .freqGradientCa(gCa), .surgeDetect(surgeDetect), .phaseLoss(phaseLoss));
  frequency_protection_element #(.TICK_CYCLES(TICK)) frequency_protection_element_inst (
    .clk(clk), .nrst(nrst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
    .voltagePhaseAb(vAb), .voltagePhaseBc(vBc), .voltagePhaseCa(vCa), .freqAb(fAb),
    .freqBc(fBc), .freqCa(fCa), .freqGradientAb(gAb), .freqGradientBc(gBc),
    .freqGradientCa(gCa), .surgeDetect(surgeDetect), .phaseLoss(phaseLoss),
    .extBlock(extBlock), .alarm(alarm), .trip(trip), .mainsFailTrip(mainsFailTrip), .irq(irq));
  // ------------------------------------------------------------
  // Tasks.
  // ------------------------------------------------------------
  task automatic test_done();
    $display("Checks %0d, mismatches %0d.", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_pin(input string what, input logic exp, input logic got);
    chk_reg(what, {31'h0, exp}, {31'h0, got});
  endtask
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (waitrequest === 1'b0) break;
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (i == 20) begin
      chk_pin("bus answer", 1'b0, waitrequest);
      test_done();
    end
  endtask
  task automatic wait_pin(input logic selTrip, input logic v, output int n);
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if ((selTrip ? trip : alarm) === v) break;
    end
    if (n == 100) begin
      chk_pin("wait", v, selTrip ? trip : alarm);
      test_done();
    end
  endtask
  task automatic run_case(input case_s c, input logic [1:0] ph);
    int n;
    bus(1'b1, freq_prot_pkg::OFS_FREQ_THR, {16'h0000, c.thr});
    bus(1'b1, freq_prot_pkg::OFS_CTRL, {26'h0, c.d, c.m, 1'b1});
    setFreq <= c.f;
    setGrad <= c.g;
    setPhase <= ph;
    repeat (4) @(posedge clk);
    chk_pin("alarm", c.e, alarm);
    if (c.e) begin
      wait_pin(c.m < 3'h3, c.m < 3'h3, n);
      chk_pin("trip delay", 1'b1, n >= 3 * TICK / 2 && trip === (c.m < 3'h3));
    end
    setFreq <= 16'h1388;
    setGrad <= 16'sh0000;
    repeat (4) @(posedge clk);
    chk_pin("drop", 1'b0, alarm | trip);
  endtask
  // ------------------------------------------------------------
  // Sequence.
  // ------------------------------------------------------------
  initial begin
    int n;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    bus(1'b0, freq_prot_pkg::OFS_CTRL, 32'h0000_0000);
    chk_reg("ctrl reset", 32'h0000_0000, q);
    bus(1'b0, 6'h3C, 32'h0000_0000);
    chk_reg("unmapped", 32'h0000_0000, q);
    bus(1'b1, freq_prot_pkg::OFS_STATE, 32'h0000_0033);
    bus(1'b0, freq_prot_pkg::OFS_STATE, 32'h0000_0000);
    chk_reg("state ro", 32'h0000_0000, q);
    bus(1'b1, freq_prot_pkg::OFS_UV_THR, 32'h0000_0100);
    bus(1'b1, freq_prot_pkg::OFS_GRAD_THR, 32'h0000_0010);
    bus(1'b1, freq_prot_pkg::OFS_TRIP_DELAY, 32'h0000_0003);
    bus(1'b1, freq_prot_pkg::OFS_CHANGE_THR, 32'h0000_0100);
    bus(1'b1, freq_prot_pkg::OFS_INTERVAL, 32'h0000_0004);
    bus(1'b0, freq_prot_pkg::OFS_GRAD_THR, 32'h0000_0000);
    chk_reg("grad thr", 32'h0000_0010, q);
    for (int i = 0; i < 11; i++) begin
      run_case(cases[i], 2'(i % 3));
    end
    extBlock <= 1'b1;
    bus(1'b1, freq_prot_pkg::OFS_CTRL, 32'h0000_0021);
    setGrad <= 16'sh0020;
    repeat (4) @(posedge clk);
    chk_pin("blocked alarm", 1'b0, alarm);
    extBlock <= 1'b0;
    repeat (8) @(posedge clk);
    setGrad <= 16'sh0000;
    repeat (60) @(posedge clk);
    chk_pin("early clear", 1'b0, alarm | trip);
    bus(1'b1, freq_prot_pkg::OFS_FREQ_THR, 32'h0000_1340);
    bus(1'b1, freq_prot_pkg::OFS_CTRL, {26'h0, 2'h0, freq_prot_pkg::MODE_UNDER_CHG, 1'b1});
    setPhase <= 2'h1;
    setFreq <= 16'h1300;
    repeat (4) @(posedge clk);
    chk_pin("interval alarm", 1'b1, alarm);
    wait_pin(1'b0, 1'b0, n);
    chk_pin("expired", 1'b1, n >= 2 * TICK && trip === 1'b0);
    setFreq <= 16'h1200;
    repeat (4) @(posedge clk);
    chk_pin("inhibited", 1'b0, alarm | trip);
    setFreq <= 16'h1388;
    repeat (4) @(posedge clk);
    setFreq <= 16'h1300;
    repeat (4) @(posedge clk);
    setFreq <= 16'h1200;
    wait_pin(1'b1, 1'b1, n);
    chk_pin("change trip", 1'b1, n < 4);
    setFreq <= 16'h1388;
    bus(1'b1, freq_prot_pkg::OFS_CTRL, 32'h0000_0021);
    setGrad <= 16'sh0020;
    repeat (4) @(posedge clk);
    setVolt <= 16'h0080;
    repeat (4) @(posedge clk);
    chk_pin("uv alarm", 1'b0, alarm);
    setVolt <= 16'h1000;
    repeat (400 * TICK) @(posedge clk);
    bus(1'b0, freq_prot_pkg::OFS_STATE, 32'h0000_0000);
    chk_pin("uv hold", 1'b1, q[3]);
    repeat (110 * TICK) @(posedge clk);
    bus(1'b0, freq_prot_pkg::OFS_STATE, 32'h0000_0000);
    chk_pin("uv gone", 1'b0, q[3] | alarm);
    repeat (520 * TICK) @(posedge clk);
    chk_pin("grad back", 1'b1, alarm);
    setGrad <= 16'sh0000;
    bus(1'b1, freq_prot_pkg::OFS_STATUS, 32'h0000_000F);
    bus(1'b1, freq_prot_pkg::OFS_MASK, 32'h0000_0000);
    bus(1'b1, freq_prot_pkg::OFS_CTRL, {26'h0, 2'h0, freq_prot_pkg::MODE_SURGE, 1'b1});
    setSurge <= 1'b1;
    repeat (4) @(posedge clk);
    chk_pin("surge trip", 1'b1, mainsFailTrip & ~irq);
    setSurge <= 1'b0;
    bus(1'b0, freq_prot_pkg::OFS_STATUS, 32'h0000_0000);
    chk_reg("status", 32'h0000_0004, q);
    bus(1'b1, freq_prot_pkg::OFS_MASK, 32'h0000_0004);
    repeat (2) @(posedge clk);
    chk_pin("irq set", 1'b1, irq);
    bus(1'b1, freq_prot_pkg::OFS_STATUS, 32'h0000_0004);
    repeat (2) @(posedge clk);
    chk_pin("irq clear", 1'b0, irq);
    setLoss <= 1'b1;
    setSurge <= 1'b1;
    repeat (4) @(posedge clk);
    chk_pin("loss", 1'b0, mainsFailTrip);
    setSurge <= 1'b0;
    setLoss <= 1'b0;
    repeat (2) @(posedge clk);
    setVolt <= 16'h0080;
    setSurge <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      chk_pin("uv surge", 1'b0, mainsFailTrip);
    end
    test_done();
  end
endmodule
bind frequency_protection_element freq_prot_asserts #(.TICK_CYCLES(TICK_CYCLES)) chk_inst (
  .clk(clk), .nrst(nrst), .address(address), .read(read), .write(write),
  .readdata(readdata), .waitrequest(waitrequest), .surgeDetect(surgeDetect),
  .phaseLoss(phaseLoss), .extBlock(extBlock), .alarm(alarm), .trip(trip),
  .mainsFailTrip(mainsFailTrip), .irq(irq));
